// file: sleep_mode_power_sequencer_bench.sv
// testbench for the sleep mode power sequencer
// assumes smps_pkg, the checker and the pad model are compiled first
`timescale 1ns/1ps
module sleep_mode_power_sequencer_bench;
    import smps_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, sleep = 1'b0;
    smps_delays_t delays = '0;
    logic [3:0] pad_values = 4'ha, pad_wire, pad_out, pad_oe_b;
    logic [15:0] gce;
    logic ioe, lpi;
    smps_counts_t counts;
    int n_fail = 0, n_checks = 0;
    always #2.5 clk = ~clk;
    smps_sequencer DUT (.clk(clk), .rst_b(rst_b), .sleep(sleep), .delays(delays),
        .pad_values(pad_values), .global_clock_enables(gce), .io_buffer_enable(ioe),
        .low_power_indicator(lpi), .counts(counts), .demo_pad_outputs(pad_out),
        .demo_pad_oe_b(pad_oe_b));
    smps_far_model u_far (.clk(clk), .pad_out(pad_out), .pad_oe_b(pad_oe_b),
        .pad_wire(pad_wire));
    // ----
    // tasks
    // ----
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic tick(inout int n);
        @(negedge clk);
        n++;
    endtask
    // one full sleep and wake; sh drops sleep early, during entering
    task automatic cycle(input logic [23:0] d, input int e1, e2, e4, input bit sh);
        int n;
        logic [7:0] c;
        delays = d;
        sleep = 1'b1;
        n = 0;
        while (lpi !== 1'b1 && n < 20) tick(n);
        chk("ioe_entering", 24'h1, ioe);
        if (sh) sleep = 1'b0;
        n = 0;
        while (ioe === 1'b1 && n < 99) tick(n);
        chk("io_off_wait", 24'(e1), 24'(n));
        chk("oe_b_off", 24'hf, pad_oe_b);
        n = 0;
        while (gce === 16'hffff && n < 99) tick(n);
        chk("clk_off_wait", 24'(e2), 24'(n));
        chk("gce_off0", 24'hffc0, gce);
        tick(n);
        chk("gce_off1", 24'hf800, gce);
        tick(n);
        chk("gce_off2", 24'h0, gce);
        c = counts.count;
        chk("entry_snap", c, counts.count_at_sleep_entry);
        if (!sh) begin
            repeat (8) tick(n);
            chk("asleep", {c, 16'h0}, {counts.count, gce});
            sleep = 1'b0;
        end
        n = 0;
        while (gce === 16'h0 && n < 99) tick(n);
        chk("gce_on0", 24'h3f, gce);
        tick(n);
        chk("gce_on1", 24'h7ff, gce);
        tick(n);
        chk("gce_on2", 24'hffff, gce);
        n = 0;
        while (ioe !== 1'b1 && n < 99) tick(n);
        chk("io_on_wait", 24'(e4), 24'(n));
        chk("lpi_low", 24'h0, lpi);
        chk("exit_snap", c, counts.count_at_sleep_exit);
        chk("pads", pad_values, pad_wire);
        c = counts.count;
        tick(n);
        chk("resumed", 8'(c + 8'h01), counts.count);
        repeat (20) tick(n);
        chk("awake", 24'h1ffff, {lpi, ioe, gce});
    endtask
    // ----
    // sequence
    // ----
    initial begin
        repeat (10) @(negedge clk);
        chk("rst_ctl", 24'h1ffff, {lpi, ioe, gce});
        chk("rst_cnt", 24'h0, counts);
        rst_b = 1'b1;
        repeat (5) @(negedge clk);
        cycle({6'h00, 6'h00, 6'h00, 6'h00}, 1, 12, 40, 1'b0);
        cycle({6'h05, 6'h14, 6'h03, 6'h2d}, 5, 21, 45, 1'b0);
        cycle({6'h01, 6'h0b, 6'h01, 6'h28}, 1, 12, 40, 1'b1);
        close_out();
    end
    initial begin
        #(5 * 20000);
        n_fail++;
        close_out();
    end
endmodule

// file: smps_defines.svh
// constants for the sleep mode power sequencer
// assumes inclusion by bare name from the package and the modules
`ifndef SMPS_DEFINES_SVH
`define SMPS_DEFINES_SVH
`define SMPS_DLY_W 6
`define SMPS_CNT_W 8
`define SMPS_CLK_N 16
`define SMPS_PAD_N 4
`define SMPS_IO_OFF_MIN 6'h01
`define SMPS_CLK_OFF_MIN 6'h0b
`define SMPS_CLK_ON_MIN 6'h01
`define SMPS_IO_ON_MIN 6'h28
`define SMPS_GRP0 16'h003f
`define SMPS_GRP1 16'h07ff
`define SMPS_ALL_ON 16'hffff
`define SMPS_ALL_OFF 16'h0000
`define SMPS_CNT_RST 8'h00
`define SMPS_DLY_ZERO 6'h00
`define SMPS_DLY_ONE 6'h01
`define SMPS_STEP_W 2
`define SMPS_STEP0 2'h0
`define SMPS_STEP1 2'h1
`define SMPS_STEP2 2'h2
`define SMPS_PHASE_W 2
`define SMPS_PH_IO 2'h0
`define SMPS_PH_WAIT 2'h1
`define SMPS_PH_CLK 2'h2
`endif

// file: smps_demo_logic.sv
// demonstration user logic: free-running counter with snapshots and pads
// assumes freeze and capture strobes from the sequencer on the same clock
`timescale 1ns/1ps
`include "smps_defines.svh"
module smps_demo_logic (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control from the sequencer
    input wire logic freeze,
    input wire logic capture_entry,
    input wire logic capture_exit,
    input wire logic io_buffer_enable,
    input wire logic [`SMPS_PAD_N-1:0] pad_values,
    // results
    output smps_pkg::smps_counts_t counts,
    output logic [`SMPS_PAD_N-1:0] demo_pad_out,
    output logic [`SMPS_PAD_N-1:0] demo_pad_oe_b
);
    import smps_pkg::*;

    smps_counts_t counts_ff;
    smps_counts_t nxt_counts;
    logic [`SMPS_PAD_N-1:0] pad_ff;
    logic [`SMPS_PAD_N-1:0] nxt_pad;
    logic [`SMPS_PAD_N-1:0] oe_b_ff;
    logic [`SMPS_PAD_N-1:0] nxt_oe_b;

    always_comb begin
        nxt_counts = counts_ff;
        if (!freeze) begin
            nxt_counts.count = counts_ff.count + `SMPS_CNT_W'(1);
        end
        if (capture_entry) begin
            nxt_counts.count_at_sleep_entry = counts_ff.count;
        end
        if (capture_exit) begin
            nxt_counts.count_at_sleep_exit = counts_ff.count;
        end
        nxt_pad = pad_values;
        // pads float while buffers are off, drive again once enabled
        nxt_oe_b = {`SMPS_PAD_N{~io_buffer_enable}};
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            counts_ff <= '0;
            pad_ff <= '0;
            oe_b_ff <= '0;
        end else begin
            counts_ff <= nxt_counts;
            pad_ff <= nxt_pad;
            oe_b_ff <= nxt_oe_b;
        end
    end

    assign counts = counts_ff;
    assign demo_pad_out = pad_ff;
    assign demo_pad_oe_b = oe_b_ff;
endmodule

// file: smps_far_model.sv
// far side of the demo pads: resolves the pad wire from value and enable
// assumes oe_b low while the sequencer drives; no pull on the wire
`timescale 1ns/1ps
module smps_far_model (
    // clock
    input wire logic clk,
    // pad drive
    input wire logic [3:0] pad_out,
    input wire logic [3:0] pad_oe_b,
    // resolved wire
    output logic [3:0] pad_wire
);
    logic [3:0] last_ff;
    // a released wire keeps changing so no stale value passes
    always_ff @(posedge clk) begin
        last_ff <= pad_wire;
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pad_wire[i] = pad_oe_b[i] ? ~last_ff[i] : pad_out[i];
        end
    end
endmodule

// file: smps_pkg.sv
// types for the sleep mode power sequencer
// assumes smps_defines.svh is on the include path
`include "smps_defines.svh"
package smps_pkg;
    typedef enum logic [3:0] {
        SMPS_AWAKE = 4'h1,
        SMPS_ENTER = 4'h2,
        SMPS_SLEEP = 4'h4,
        SMPS_EXIT = 4'h8
    } smps_state_t;
    // the four programmable sequencing delays, in clock cycles
    typedef struct packed {
        logic [`SMPS_DLY_W-1:0] io_off_delay;
        logic [`SMPS_DLY_W-1:0] clock_off_delay;
        logic [`SMPS_DLY_W-1:0] clock_on_delay;
        logic [`SMPS_DLY_W-1:0] io_on_delay;
    } smps_delays_t;
    // demonstration counter snapshot outputs
    typedef struct packed {
        logic [`SMPS_CNT_W-1:0] count;
        logic [`SMPS_CNT_W-1:0] count_at_sleep_entry;
        logic [`SMPS_CNT_W-1:0] count_at_sleep_exit;
    } smps_counts_t;
endpackage

// file: smps_seq_props.sv
// assertions on the sleep mode power sequencer ports
// assumes one clock domain, rst_b async active low
`timescale 1ns/1ps
`include "smps_defines.svh"
module smps_seq_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // inputs
    input wire logic sleep,
    input smps_pkg::smps_delays_t delays,
    input wire logic [3:0] pad_values,
    // outputs
    input wire logic [15:0] global_clock_enables,
    input wire logic io_buffer_enable,
    input wire logic low_power_indicator,
    input smps_pkg::smps_counts_t counts,
    input wire logic [3:0] demo_pad_outputs,
    input wire logic [3:0] demo_pad_oe_b
);
    import smps_pkg::*;
    logic [5:0] off_cnt_ff, nxt_off_cnt, on_cnt_ff, nxt_on_cnt;
    // ----
    // cycles buffers off before gating, cycles clocks on before buffers
    // ----
    always_comb begin
        nxt_off_cnt = 6'h00;
        nxt_on_cnt = 6'h00;
        if (!io_buffer_enable && global_clock_enables == 16'hffff) begin
            nxt_off_cnt = (off_cnt_ff == 6'h3f) ? off_cnt_ff : off_cnt_ff + 6'h01;
        end
        if (!io_buffer_enable && global_clock_enables == 16'hffff) begin
            nxt_on_cnt = (on_cnt_ff == 6'h3f) ? on_cnt_ff : on_cnt_ff + 6'h01;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            off_cnt_ff <= 6'h00;
            on_cnt_ff <= 6'h00;
        end else begin
            off_cnt_ff <= nxt_off_cnt;
            on_cnt_ff <= nxt_on_cnt;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ----
    // properties
    // ----
    AST_OE_MIRROR: assert property (demo_pad_oe_b == {4{!io_buffer_enable}})
        else $error("pad enable does not follow buffer enable");
    AST_CLK_OFF_SEQ: assert property ($fell(global_clock_enables[0]) |->
        global_clock_enables == 16'hffc0 ##1 global_clock_enables == 16'hf800
        ##1 global_clock_enables == 16'h0000)
        else $error("clock enables not cleared in three steps");
    AST_CLK_ON_SEQ: assert property ($rose(global_clock_enables[0]) |->
        global_clock_enables == 16'h003f ##1 global_clock_enables == 16'h07ff
        ##1 global_clock_enables == 16'hffff)
        else $error("clock enables not set in three steps");
    AST_IO_FIRST: assert property ($fell(global_clock_enables[0]) |->
        !io_buffer_enable && low_power_indicator && off_cnt_ff >= 6'h0c)
        else $error("clocks gated too soon after buffers off");
    AST_IO_ON_LATE: assert property ($rose(io_buffer_enable) |->
        global_clock_enables == 16'hffff && on_cnt_ff >= 6'h28)
        else $error("buffers on too soon after clocks on");
    AST_IND_FALL: assert property ($fell(low_power_indicator) |-> $rose(io_buffer_enable))
        else $error("indicator fell apart from buffer power up");
    AST_IND_RISE: assert property ($rose(low_power_indicator) |->
        io_buffer_enable && global_clock_enables == 16'hffff)
        else $error("indicator rose after power down began");
    AST_FROZEN: assert property (global_clock_enables == 16'h0000 |->
        $stable(counts.count))
        else $error("counter moved while asleep");
    AST_SNAP_EQ: assert property ($rose(io_buffer_enable) |->
        counts.count_at_sleep_exit == counts.count_at_sleep_entry)
        else $error("exit snapshot differs from entry snapshot");
    AST_RUNS: assert property (io_buffer_enable && !low_power_indicator &&
        $past(io_buffer_enable && !low_power_indicator && rst_b) |->
        counts.count == $past(counts.count) + 8'h01)
        else $error("counter not running while awake");
    cover property ($fell(global_clock_enables[0]));
    cover property ($rose(io_buffer_enable));
    cover property (global_clock_enables == 16'h0000 && !sleep);
endmodule
bind smps_sequencer smps_seq_props u_props (.clk(clk), .rst_b(rst_b), .sleep(sleep),
    .delays(delays), .pad_values(pad_values), .global_clock_enables(global_clock_enables),
    .io_buffer_enable(io_buffer_enable), .low_power_indicator(low_power_indicator),
    .counts(counts), .demo_pad_outputs(demo_pad_outputs), .demo_pad_oe_b(demo_pad_oe_b));

// file: smps_sequencer.sv
// sleep mode power sequencer: gates io buffers and sixteen clock enables
// assumes clk is an ungated free-running oscillator; sleep may be async
`timescale 1ns/1ps
`include "smps_defines.svh"
// Functional notes
// - sleep high starts the entering state, powering down buffers and clocks
// - after power-down completes, go to sleep state and wait for wake
// - sleep low starts the exiting state, powering clocks and buffers up
// - after power-up completes, go awake; the cycle repeats on next sleep
// - after io_off_delay, deassert io_buffer_enable to power buffers down
// - after clock_off_delay, clear clock enables lsb to msb within three cycles
// - stay in sleep with clocks and buffers off while sleep stays high
// - capture counter to entry output before sleep, then freeze counter
// - demo pads float while io_buffer_enable is low
// - after clock_on_delay, set clock enables lsb to msb within three cycles
// - after further io_on_delay, reassert io_buffer_enable
// - remain awake with clocks and buffers on until sleep rises again
// - capture counter to exit output before awake, then release freeze
// - demo pads drive again once io_buffer_enable is high
// - delays are 6-bit counts; io_off at least 1, clock_off at least 11
// - clock_on at least 1, io_on at least 40; larger values allowed
// - low_power_indicator high from sleep entry until exit fully completes
// - demo logic is a free-running 8-bit counter with 8-bit snapshots
module smps_sequencer (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // sleep request from outside the clock domain
    input wire logic sleep,
    // programmable sequencing delays
    input smps_pkg::smps_delays_t delays,
    // demo pad values from user logic
    input wire logic [`SMPS_PAD_N-1:0] pad_values,
    // power controls
    output logic [`SMPS_CLK_N-1:0] global_clock_enables,
    output logic io_buffer_enable,
    output logic low_power_indicator,
    // demo outputs
    output smps_pkg::smps_counts_t counts,
    output logic [`SMPS_PAD_N-1:0] demo_pad_outputs,
    output logic [`SMPS_PAD_N-1:0] demo_pad_oe_b
);
    import smps_pkg::*;

    // ------------------------------------------------------------
    // sleep input synchroniser
    // ------------------------------------------------------------
    logic sleep_meta_ff;
    logic sleep_sync_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sleep_meta_ff <= 1'b0;
            sleep_sync_ff <= 1'b0;
        end else begin
            sleep_meta_ff <= sleep;
            sleep_sync_ff <= sleep_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // delay clamping to the required minimums
    // ------------------------------------------------------------
    logic [`SMPS_DLY_W-1:0] io_off_eff;
    logic [`SMPS_DLY_W-1:0] clk_off_eff;
    logic [`SMPS_DLY_W-1:0] clk_on_eff;
    logic [`SMPS_DLY_W-1:0] io_on_eff;

    // values below a minimum are raised to it, never rejected
    function automatic logic [`SMPS_DLY_W-1:0] clamp_min(
        input logic [`SMPS_DLY_W-1:0] val,
        input logic [`SMPS_DLY_W-1:0] lo
    );
        clamp_min = (val < lo) ? lo : val;
    endfunction

    always_comb begin
        io_off_eff = clamp_min(delays.io_off_delay, `SMPS_IO_OFF_MIN);
        clk_off_eff = clamp_min(delays.clock_off_delay, `SMPS_CLK_OFF_MIN);
        clk_on_eff = clamp_min(delays.clock_on_delay, `SMPS_CLK_ON_MIN);
        io_on_eff = clamp_min(delays.io_on_delay, `SMPS_IO_ON_MIN);
    end

    // ------------------------------------------------------------
    // sequencing state machine
    // ------------------------------------------------------------
    smps_state_t state_ff;
    smps_state_t nxt_state;
    logic [`SMPS_PHASE_W-1:0] phase_ff;
    logic [`SMPS_PHASE_W-1:0] nxt_phase;
    logic [`SMPS_DLY_W-1:0] dly_ff;
    logic [`SMPS_DLY_W-1:0] nxt_dly;
    logic [`SMPS_STEP_W-1:0] step_ff;
    logic [`SMPS_STEP_W-1:0] nxt_step;
    logic [`SMPS_CLK_N-1:0] clk_en_ff;
    logic [`SMPS_CLK_N-1:0] nxt_clk_en;
    logic io_en_ff;
    logic nxt_io_en;
    logic lpi_ff;
    logic nxt_lpi;
    logic freeze_ff;
    logic nxt_freeze;
    logic cap_entry;
    logic cap_exit;
    logic dly_done;
    logic dly_load;
    logic [`SMPS_DLY_W-1:0] dly_load_val;
    logic gate_go;
    logic ungate_go;

    assign dly_done = (dly_ff == `SMPS_DLY_ONE);

    always_comb begin
        nxt_state = state_ff;
        nxt_phase = phase_ff;
        dly_load = 1'b0;
        dly_load_val = `SMPS_DLY_ZERO;
        nxt_step = step_ff;
        gate_go = 1'b0;
        ungate_go = 1'b0;
        nxt_io_en = io_en_ff;
        nxt_lpi = lpi_ff;
        nxt_freeze = freeze_ff;
        cap_entry = 1'b0;
        cap_exit = 1'b0;
        case (state_ff)
            SMPS_AWAKE: begin
                if (sleep_sync_ff) begin
                    nxt_state = SMPS_ENTER;
                    nxt_phase = `SMPS_PH_IO;
                    dly_load = 1'b1;
                    dly_load_val = io_off_eff;
                    nxt_lpi = 1'b1;
                end
            end
            SMPS_ENTER: begin
                case (phase_ff)
                    `SMPS_PH_IO: begin
                        if (dly_done) begin
                            nxt_io_en = 1'b0;
                            nxt_phase = `SMPS_PH_WAIT;
                            dly_load = 1'b1;
                            dly_load_val = clk_off_eff;
                        end
                    end
                    `SMPS_PH_WAIT: begin
                        if (dly_done) begin
                            nxt_phase = `SMPS_PH_CLK;
                            nxt_step = `SMPS_STEP0;
                            cap_entry = 1'b1;
                            nxt_freeze = 1'b1;
                        end
                    end
                    default: begin
                        gate_go = 1'b1;
                        case (step_ff)
                            `SMPS_STEP0: begin
                                nxt_step = `SMPS_STEP1;
                            end
                            `SMPS_STEP1: begin
                                nxt_step = `SMPS_STEP2;
                            end
                            default: begin
                                nxt_state = SMPS_SLEEP;
                            end
                        endcase
                    end
                endcase
            end
            SMPS_SLEEP: begin
                if (!sleep_sync_ff) begin
                    nxt_state = SMPS_EXIT;
                    nxt_phase = `SMPS_PH_WAIT;
                    dly_load = 1'b1;
                    dly_load_val = clk_on_eff;
                end
            end
            SMPS_EXIT: begin
                case (phase_ff)
                    `SMPS_PH_WAIT: begin
                        if (dly_done) begin
                            nxt_phase = `SMPS_PH_CLK;
                            nxt_step = `SMPS_STEP0;
                        end
                    end
                    `SMPS_PH_CLK: begin
                        ungate_go = 1'b1;
                        case (step_ff)
                            `SMPS_STEP0: begin
                                nxt_step = `SMPS_STEP1;
                            end
                            `SMPS_STEP1: begin
                                nxt_step = `SMPS_STEP2;
                            end
                            default: begin
                                nxt_phase = `SMPS_PH_IO;
                                dly_load = 1'b1;
                                dly_load_val = io_on_eff;
                            end
                        endcase
                    end
                    default: begin
                        if (dly_done) begin
                            nxt_io_en = 1'b1;
                            cap_exit = 1'b1;
                            nxt_freeze = 1'b0;
                            nxt_lpi = 1'b0;
                            nxt_state = SMPS_AWAKE;
                        end
                    end
                endcase
            end
            default: begin
                nxt_state = SMPS_AWAKE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= SMPS_AWAKE;
            phase_ff <= `SMPS_PH_IO;
            step_ff <= `SMPS_STEP0;
            io_en_ff <= 1'b1;
            lpi_ff <= 1'b0;
            freeze_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            phase_ff <= nxt_phase;
            step_ff <= nxt_step;
            io_en_ff <= nxt_io_en;
            lpi_ff <= nxt_lpi;
            freeze_ff <= nxt_freeze;
        end
    end

    // ------------------------------------------------------------
    // sequencing delay counter
    // ------------------------------------------------------------
    always_comb begin
        nxt_dly = dly_ff;
        if (dly_load) begin
            nxt_dly = dly_load_val;
        end else if (dly_ff != `SMPS_DLY_ZERO) begin
            nxt_dly = dly_ff - `SMPS_DLY_ONE;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dly_ff <= `SMPS_DLY_ZERO;
        end else begin
            dly_ff <= nxt_dly;
        end
    end

    // ------------------------------------------------------------
    // clock enable staging
    // ------------------------------------------------------------
    // one group per cycle keeps the supply step small on gate and ungate
    always_comb begin
        nxt_clk_en = clk_en_ff;
        if (gate_go) begin
            case (step_ff)
                `SMPS_STEP0: begin
                    nxt_clk_en = clk_en_ff & ~`SMPS_GRP0;
                end
                `SMPS_STEP1: begin
                    nxt_clk_en = clk_en_ff & ~`SMPS_GRP1;
                end
                default: begin
                    nxt_clk_en = `SMPS_ALL_OFF;
                end
            endcase
        end else if (ungate_go) begin
            case (step_ff)
                `SMPS_STEP0: begin
                    nxt_clk_en = clk_en_ff | `SMPS_GRP0;
                end
                `SMPS_STEP1: begin
                    nxt_clk_en = clk_en_ff | `SMPS_GRP1;
                end
                default: begin
                    nxt_clk_en = `SMPS_ALL_ON;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_en_ff <= `SMPS_ALL_ON;
        end else begin
            clk_en_ff <= nxt_clk_en;
        end
    end

    // ------------------------------------------------------------
    // demonstration user logic
    // ------------------------------------------------------------
    smps_demo_logic u_demo (
        .clk(clk),
        .rst_b(rst_b),
        .freeze(nxt_freeze),
        .capture_entry(cap_entry),
        .capture_exit(cap_exit),
        .io_buffer_enable(nxt_io_en),
        .pad_values(pad_values),
        .counts(counts),
        .demo_pad_out(demo_pad_outputs),
        .demo_pad_oe_b(demo_pad_oe_b)
    );

    assign global_clock_enables = clk_en_ff;
    assign io_buffer_enable = io_en_ff;
    assign low_power_indicator = lpi_ff;
endmodule
